// ==== logic/uncorr_err_regs.vh ====
`ifndef UNCORR_ERR_REGS_VH
`define UNCORR_ERR_REGS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define ADDR_W            12
`define OFF_STATUS        12'h104
`define OFF_MASK          12'h108
`define OFF_CTL           12'h118
`define OFF_IRQ_STATUS    12'h800
`define OFF_IRQ_MASK      12'h804

// ************************************************************
// Field positions and layouts
// ************************************************************
`define BIT_UNUSED0       0
`define BIT_LINK_PROTO    4
`define BIT_SURPRISE_DN   5
`define BIT_POISONED      12
`define BIT_FLOW_CTL      13
`define BIT_CPL_TIMEOUT   14
`define BIT_CPL_ABORT     15
`define BIT_UNEXP_CPL     16
`define BIT_RX_OVERFLOW   17
`define BIT_MALFORMED     18
`define BIT_ECRC          19
`define BIT_UNSUPP_REQ    20
`define BIT_ACS_VIOL      21
// Writable mask bits: 0, 4, 5, 12, 13, 16..21
`define MASK_RW_BITS      32'h003f3031
// Status bits that hardware may set
`define STATUS_SET_BITS   32'h003f3030
`define FEP_W             5
`define CTL_FEP_LSB       0
`define IRQ_W             2
`define IRQ_BIT_REPORT    0
`define IRQ_BIT_MASKED    1

// ************************************************************
// Reset values
// ************************************************************
`define MASK_RESET        32'h00000000
`define STATUS_RESET      32'h00000000
`define ZERO32            32'h00000000

`endif

// ==== logic/uncorr_err_mask.v ====
// Behaviour
// - Masked error class: status bit still logged, first-error pointer held, no report upstream.
// - Mask never stops the matching status bit from being set.
// - Bits 4 and 5 mask link protocol and surprise down; RW sticky, reset 0.
// - Bit 13 masks flow control protocol errors; RW sticky, reset 0.
// - Bits 12, 16, 17 mask poisoned, unexpected completion, overflow; RW sticky, 0.
// - Bits 18, 19, 21 mask malformed, end-to-end CRC, ACS violation; RW sticky, 0.
// - Bit 20 masks unsupported requests; RW sticky, reset 0, gates like others.
// - Bit 14 completion timeout mask reads zero, writes ignored.
// - Bit 15 completer abort mask is read-only zero.
// - Bit 0 is RW sticky storage, reset 0, no effect on handling.
// - Status bit set on detection, cleared by writing one, regardless of mask.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "uncorr_err_regs.vh"

module uncorr_err_mask #(
    parameter DATA_W = 32
) (
    input  wire                clk_sys,
    input  wire                reset,
    input  wire                pwr_on_reset,
    input  wire [`ADDR_W-1:0]  addr,
    input  wire [DATA_W-1:0]   wdata,
    input  wire                wr_stb,
    input  wire                rd_stb,
    input  wire [DATA_W-1:0]   err_detect,
    output reg  [DATA_W-1:0]   rdata,
    output reg                 err_report,
    output reg  [DATA_W-1:0]   err_report_vec,
    output reg                 irq
);

// ************************************************************
// Decode helper
// ************************************************************
    function hit;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Lowest set bit index, used for the first-error pointer
    function [`FEP_W-1:0] first_set;
        input [DATA_W-1:0] v;
        integer i;
        begin
            first_set = {`FEP_W{1'b0}};
            for (i = DATA_W - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[`FEP_W-1:0];
                end
            end
        end
    endfunction

// ************************************************************
// Registers
// ************************************************************
    reg  [DATA_W-1:0]  mask_q;
    reg  [DATA_W-1:0]  mask_d;
    reg  [DATA_W-1:0]  status_q;
    reg  [DATA_W-1:0]  status_d;
    reg  [`FEP_W-1:0]  fep_q;
    reg  [`FEP_W-1:0]  fep_d;
    reg  [`IRQ_W-1:0]  irq_status_q;
    reg  [`IRQ_W-1:0]  irq_status_d;
    reg  [`IRQ_W-1:0]  irq_mask_q;
    reg  [`IRQ_W-1:0]  irq_mask_d;
    reg  [DATA_W-1:0]  rdata_d;

    wire               wr_mask   = wr_stb && hit(addr, `OFF_MASK);
    wire               wr_status = wr_stb && hit(addr, `OFF_STATUS);
    wire               wr_imask  = wr_stb && hit(addr, `OFF_IRQ_MASK);
    wire               wr_istat  = wr_stb && hit(addr, `OFF_IRQ_STATUS);
    wire [DATA_W-1:0]  detect    = err_detect & `STATUS_SET_BITS;
    // Events not masked are the only ones that report and load the pointer; all set status
    wire [DATA_W-1:0]  unmasked  = detect & ~mask_q;
    wire [DATA_W-1:0]  masked    = detect & mask_q;
    // Pointer is only loaded when no unmasked logged status bit is still pending
    wire               fep_free  = ((status_q & ~mask_q) == `ZERO32);

// ************************************************************
// Next-state logic
// ************************************************************
    always @* begin
        // Only implemented bits take writes; 14, 15 and reserved stay 0
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = wdata & `MASK_RW_BITS;
        end
        // Set wins over a write-one clear arriving in the same cycle
        status_d = status_q;
        if (wr_status) begin
            status_d = status_d & ~(wdata & `STATUS_SET_BITS);
        end
        status_d = status_d | detect;
        fep_d = fep_q;
        if ((unmasked != `ZERO32) && fep_free) begin
            fep_d = first_set(unmasked);
        end
        irq_mask_d = irq_mask_q;
        if (wr_imask) begin
            irq_mask_d = wdata[`IRQ_W-1:0];
        end
        irq_status_d = irq_status_q;
        if (wr_istat) begin
            irq_status_d = irq_status_d & ~wdata[`IRQ_W-1:0];
        end
        if (unmasked != `ZERO32) begin
            irq_status_d[`IRQ_BIT_REPORT] = 1'b1;
        end
        if (masked != `ZERO32) begin
            irq_status_d[`IRQ_BIT_MASKED] = 1'b1;
        end
        rdata_d = `ZERO32;
        if (rd_stb) begin
            if (hit(addr, `OFF_MASK)) begin
                rdata_d = mask_q & `MASK_RW_BITS;
            end else if (hit(addr, `OFF_STATUS)) begin
                rdata_d = status_q;
            end else if (hit(addr, `OFF_CTL)) begin
                rdata_d = {{(DATA_W-`FEP_W){1'b0}}, fep_q};
            end else if (hit(addr, `OFF_IRQ_STATUS)) begin
                rdata_d = {{(DATA_W-`IRQ_W){1'b0}}, irq_status_q};
            end else if (hit(addr, `OFF_IRQ_MASK)) begin
                rdata_d = {{(DATA_W-`IRQ_W){1'b0}}, irq_mask_q};
            end
        end
    end

// ************************************************************
// Sticky state: cleared only by the full power-on reset
// ************************************************************
    // Ordinary or hot reset leaves these untouched by design
    always @(posedge clk_sys) begin
        if (pwr_on_reset) begin
            mask_q   <= `MASK_RESET;
            status_q <= `STATUS_RESET;
            fep_q    <= {`FEP_W{1'b0}};
        end else begin
            mask_q   <= mask_d;
            status_q <= status_d;
            fep_q    <= fep_d;
        end
    end

// ************************************************************
// Non-sticky state and outputs
// ************************************************************
    always @(posedge clk_sys) begin
        if (reset || pwr_on_reset) begin
            irq_status_q   <= {`IRQ_W{1'b0}};
            irq_mask_q     <= {`IRQ_W{1'b0}};
            rdata          <= `ZERO32;
            err_report     <= 1'b0;
            err_report_vec <= `ZERO32;
            irq            <= 1'b0;
        end else begin
            irq_status_q   <= irq_status_d;
            irq_mask_q     <= irq_mask_d;
            rdata          <= rdata_d;
            err_report     <= (unmasked != `ZERO32);
            err_report_vec <= unmasked;
            irq            <= |(irq_status_d & irq_mask_d);
        end
    end

endmodule

// ==== testbench/uncorr_err_mask_asserts.sv ====
`timescale 1ns/10ps
`include "uncorr_err_regs.vh"
module uncorr_err_mask_chk (
    input logic        clk_sys,
    input logic        reset,
    input logic        pwr_on_reset,
    input logic [11:0] addr,
    input logic [31:0] wdata,
    input logic        wr_stb,
    input logic        rd_stb,
    input logic [31:0] err_detect,
    input logic [31:0] rdata,
    input logic        err_report,
    input logic [31:0] err_report_vec
);
    // ****************************************
    // Mask shadow, cleared by full reset only
    // ****************************************
    logic [31:0] mask_q;
    always_ff @(posedge clk_sys) begin
        if (pwr_on_reset)
            mask_q <= `ZERO32;
        else if (wr_stb && addr == `OFF_MASK)
            mask_q <= wdata & `MASK_RW_BITS;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset || pwr_on_reset);
    sequence s_det; err_detect != `ZERO32; endsequence
    sequence s_stat_rd; rd_stb && addr == `OFF_STATUS; endsequence
    chk_vec_gated: assert property (err_report_vec ==
        ($past(err_detect) & ~$past(mask_q) & `STATUS_SET_BITS)) else $error("vec");
    chk_report_any: assert property (err_report == (|err_report_vec)) else $error("rep");
    chk_masked_quiet:
        assert property ((err_detect & ~mask_q & `STATUS_SET_BITS) == `ZERO32
            |=> !err_report) else $error("q");
    chk_report_fires:
        assert property ((err_detect & ~mask_q & `STATUS_SET_BITS) != `ZERO32
            |=> err_report) else $error("f");
    chk_mask_read:
        assert property (rd_stb && addr == `OFF_MASK |=> rdata == mask_q) else $error("m");
    chk_resv_zero: assert property (rd_stb && addr == `OFF_MASK
        |=> (rdata & ~`MASK_RW_BITS) == `ZERO32) else $error("resv");
    chk_status_kept: assert property (s_det ##2 s_stat_rd
        |=> (rdata & $past(err_detect, 3)) == $past(err_detect, 3)) else $error("st");
    chk_unmapped_zero:
        assert property (rd_stb && addr == 12'h000 |=> rdata == `ZERO32) else $error("u");
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`include "uncorr_err_regs.vh"
module tb;
    logic        clk_sys = 1'b0, reset = 1'b1, pwr_on_reset = 1'b1;
    logic        wr_stb = 1'b0, rd_stb = 1'b0, err_report, irq, rep;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, err_detect = 32'h0, rdata, err_report_vec, got;
    int          err_count = 0, checks_done = 0;
    int          ev[10] = '{4, 5, 12, 13, 16, 17, 18, 19, 20, 21};
    uncorr_err_mask #(.DATA_W(32)) u_uncorr_err_mask (.clk_sys, .reset, .pwr_on_reset,
        .addr, .wdata, .wr_stb, .rd_stb, .err_detect, .rdata, .err_report,
        .err_report_vec, .irq);
    always #50 clk_sys = ~clk_sys;
    // ****************************************
    // Bus, event and reset tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // Gap cycle after each access, so no strobe is driven twice in one step
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        wr_stb <= w;
        rd_stb <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        #1 got = rdata;
        @(posedge clk_sys);
    endtask
    task automatic det(input logic [31:0] v);
        err_detect <= v;
        @(posedge clk_sys);
        err_detect <= 32'h0;
        #1 got = err_report_vec;
        rep = err_report;
        @(posedge clk_sys);
    endtask
    task automatic rst(input logic p);
        reset <= 1'b1;
        pwr_on_reset <= p;
        @(posedge clk_sys);
        reset <= 1'b0;
        pwr_on_reset <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        pwr_on_reset <= 1'b0;
        acc(1'b0, `OFF_MASK, 32'h0);
        chk("mask rst", `MASK_RESET, got);
        acc(1'b1, `OFF_MASK, 32'hffffffff);
        acc(1'b0, `OFF_MASK, 32'h0);
        chk("mask all", 32'h003f3031, got);
        rst(1'b0);
        acc(1'b0, `OFF_MASK, 32'h0);
        chk("mask hot", 32'h003f3031, got);
        rst(1'b1);
        acc(1'b0, `OFF_MASK, 32'h0);
        chk("mask full", 32'h0, got);
        foreach (ev[i]) begin
            det(32'h1 << ev[i]);
            chk("vec", 32'h1 << ev[i], got);
            chk("report", 32'h1, {31'h0, rep});
        end
        acc(1'b0, `OFF_STATUS, 32'h0);
        chk("status", `STATUS_SET_BITS, got);
        acc(1'b0, `OFF_CTL, 32'h0);
        chk("pointer first", 32'h4, got);
        acc(1'b1, `OFF_STATUS, 32'hffffffff);
        // Move the pointer off bit 4 so a masked bit-4 event would show
        det(32'h00200000);
        acc(1'b1, `OFF_STATUS, 32'h00200000);
        acc(1'b1, `OFF_MASK, 32'hffffffff);
        acc(1'b1, `OFF_IRQ_MASK, 32'h0);
        acc(1'b1, `OFF_IRQ_STATUS, 32'h3);
        foreach (ev[i]) begin
            det(32'h1 << ev[i]);
            chk("masked", 32'h0, {got[31:1], rep});
            acc(1'b0, `OFF_STATUS, 32'h0);
            chk("st masked", 32'h1 << ev[i], got);
            acc(1'b1, `OFF_STATUS, 32'h1 << ev[i]);
        end
        acc(1'b0, `OFF_CTL, 32'h0);
        chk("pointer held", 32'h15, got);
        chk("irq off", 32'h0, {31'h0, irq});
        acc(1'b1, `OFF_IRQ_MASK, 32'h2);
        chk("irq on", 32'h1, {31'h0, irq});
        acc(1'b1, `OFF_IRQ_STATUS, 32'h2);
        chk("irq clr", 32'h0, {31'h0, irq});
        acc(1'b1, 12'h000, 32'hffffffff);
        acc(1'b0, 12'h000, 32'h0);
        chk("unmapped", 32'h0, got);
        print_verdict();
    end
endmodule
bind uncorr_err_mask uncorr_err_mask_chk u_uncorr_err_mask_chk (.clk_sys(clk_sys),
    .reset(reset), .pwr_on_reset(pwr_on_reset), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .err_detect(err_detect), .rdata(rdata),
    .err_report(err_report), .err_report_vec(err_report_vec));
